/* src/tmc_pkg.sv */
/*
 Constants, register offsets, field positions and the register-bus carrier for the 8-bit timer/counter.
 Assumes a single 50 MHz clock and a plain address/strobe register port.
*/
// Operation
// [RULE1] Eight-bit count wraps from FFh to 00h; the wrap is the overflow.
// [RULE2] Source select zero selects timer mode on the instruction cycle.
// [RULE3] Timer mode without prescaler advances once every instruction cycle.
// [RULE4] A software write to the count suppresses the next two increments. The code instead blocks every increment for the next two instruction cycles.
// [RULE5] Source select one selects counter mode on the external count pin.
// [RULE6] Counter mode advances on each pin edge of the chosen polarity.
// [RULE7] Edge select zero counts rising edges, one counts falling edges.
// [RULE8] One prescaler serves either this counter or the watchdog, never both.
// [RULE9] Assignment zero gives the prescaler to the counter, one to the watchdog.
// [RULE10] The prescaler count is neither readable nor writable by software.
// [RULE11] Prescaled counter ratios run in powers of two from 1:2 to 1:256.
// [RULE12] Every overflow sets the overflow flag.
// [RULE13] Enable bit zero blocks the interrupt request; the flag still sets.
// [RULE14] Software clears the flag before re-enabling; hardware never clears it.
// [RULE15] The counter stops during sleep, so overflow cannot wake the core.
// [RULE16] Counter ratio is two to the field plus one; watchdog ratio half.
// [RULE17] The flag sets regardless of individual or global enable bits.
// [RULE18] Reading the count returns it; writing loads the written value.
// [RULE19] Interrupt request is active while flag and enable are both set.
package tmc_pkg;
   localparam logic [7:0] TMC_ADDR_COUNT = 8'h01;
   localparam logic [7:0] TMC_ADDR_OPTION = 8'h81;
   localparam logic [7:0] TMC_ADDR_IRQ_CTRL = 8'h0B;
   localparam int TMC_OPT_RATE_LSB = 0;
   localparam int TMC_OPT_ASSIGN = 3;
   localparam int TMC_OPT_EDGE = 4;
   localparam int TMC_OPT_SOURCE = 5;
   localparam int TMC_IRQ_FLAG = 2;
   localparam int TMC_IRQ_ENABLE = 5;
   localparam int TMC_IRQ_GLOBAL = 7;
   localparam logic [7:0] TMC_OPTION_RESET = 8'hFF;
   localparam logic [7:0] TMC_IRQ_CTRL_RESET = 8'h00;
   localparam logic [7:0] TMC_COUNT_RESET = 8'h00;
   localparam logic [7:0] TMC_COUNT_MAX = 8'hFF;
   localparam logic [1:0] TMC_WRITE_HOLD = 2'h2;
   localparam int TMC_CLOCK_HZ = 50000000;
   localparam int TMC_INSTR_HZ = 1000000;
   localparam int TMC_INSTR_DIV = TMC_CLOCK_HZ / TMC_INSTR_HZ;
   localparam int TMC_DIV_W = 6;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } tmc_bus_s;
endpackage : tmc_pkg

/* src/tmc_prescaler.sv */
/*
 Shared 8-bit synchronous binary prescaler: counts input ticks and emits one tick per selected ratio.
 Assumes tick inputs are one-cycle pulses on the system clock.
*/
`timescale 1ns/10ps
`default_nettype none
module tmc_prescaler
   import tmc_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic clear,
   input wire logic tick_in,
   input wire logic [2:0] rate,
   input wire logic half_ratio,
   output logic tick_out
);
   logic [7:0] count;
   logic [7:0] next_count;
   logic [3:0] sel;
   logic [7:0] mask;

   // Counter ratio is 2^(rate+1); watchdog ratio is half of that. [RULE16] [RULE11]
   always_comb begin
      sel = half_ratio ? {1'b0, rate} : ({1'b0, rate} + 4'h1);
      mask = 8'(({8'h00, 8'hFF} << sel) >> 8);
      next_count = clear ? 8'h00 : (tick_in ? 8'(count + 8'h01) : count);
      tick_out = tick_in && ((count & mask) == mask);
      if (sel == 4'h0) begin
         tick_out = tick_in;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         count <= 8'h00;
      end else begin
         count <= next_count;
      end
   end
endmodule : tmc_prescaler
`default_nettype wire

/* src/tmc_timer0.sv */
/*
 Timer0 block: 8-bit timer/counter with edge select, shared prescaler, overflow flag and interrupt request.
 Assumes the core drives the register port synchronously and the count pin is synchronous to CLOCK.
*/
// The register offsets and the address-and-strobe port are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
module tmc_timer0
   import tmc_pkg::*;
(
   input wire logic CLOCK,
   input wire logic RST_N,
   input wire logic [7:0] ADDR,
   input wire logic [7:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [7:0] RDATA,
   input wire logic SLEEP,
   input wire logic EXTERNAL_COUNT_PIN,
   input wire logic WATCHDOG_TICK,
   output logic WATCHDOG_TIMEOUT_TICK,
   output logic IRQ
);
   // ==========================================================
   // Instruction-cycle enable
   // ==========================================================
   logic [TMC_DIV_W-1:0] div;
   logic [TMC_DIV_W-1:0] next_div;
   logic instr_tick;
   localparam logic [TMC_DIV_W-1:0] DIV_LAST = TMC_DIV_W'(TMC_INSTR_DIV - 1);

   always_comb begin
      instr_tick = (div == DIV_LAST);
      next_div = instr_tick ? '0 : TMC_DIV_W'(div + 1'b1);
   end

   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         div <= '0;
      end else begin
         div <= next_div;
      end
   end

   // ==========================================================
   // Registers and counting
   // ==========================================================
   tmc_bus_s bus;
   logic [7:0] count_register;
   logic [7:0] option;
   logic [7:0] irq_ctrl;
   logic [1:0] hold;
   logic pin_q;
   logic [7:0] next_count;
   logic [7:0] next_option;
   logic [7:0] next_irq_ctrl;
   logic [1:0] next_hold;
   logic [7:0] next_rdata;
   logic clock_source_select;
   logic source_edge_select;
   logic prescaler_assign;
   logic [2:0] prescale_rate_select;
   logic pin_edge;
   logic src_tick;
   logic pre_in;
   logic pre_out;
   logic inc;
   logic overflow;
   logic count_write;

   assign bus = '{addr: ADDR, wdata: WDATA, wr: WR, rd: RD};
   assign clock_source_select = option[TMC_OPT_SOURCE];
   assign source_edge_select = option[TMC_OPT_EDGE];
   assign prescaler_assign = option[TMC_OPT_ASSIGN];
   assign prescale_rate_select = option[TMC_OPT_RATE_LSB +: 3];

   // Prescaler goes to one user only; the other sees its raw tick. [RULE8] [RULE9]
   tmc_prescaler u_pre (
      .clk(CLOCK),
      .rst_n(RST_N),
      .clear(bus.wr && bus.addr == TMC_ADDR_COUNT && !prescaler_assign),
      .tick_in(pre_in),
      .rate(prescale_rate_select),
      .half_ratio(prescaler_assign),
      .tick_out(pre_out)
   );

   always_comb begin
      // Rising edge when select is zero, falling when one. [RULE6] [RULE7]
      pin_edge = source_edge_select ? (pin_q && !EXTERNAL_COUNT_PIN) : (!pin_q && EXTERNAL_COUNT_PIN);
      // Timer mode uses the instruction cycle, counter mode the pin. [RULE2] [RULE5]
      src_tick = clock_source_select ? pin_edge : instr_tick;
      pre_in = prescaler_assign ? WATCHDOG_TICK : (src_tick && !SLEEP);
      WATCHDOG_TIMEOUT_TICK = prescaler_assign ? pre_out : WATCHDOG_TICK;
      // Sleep stops the count and the counter's prescaler; a watchdog-assigned prescaler still counts. [RULE15]
      inc = !SLEEP && (prescaler_assign ? src_tick : pre_out); // [RULE3]
      count_write = bus.wr && (bus.addr == TMC_ADDR_COUNT);
      next_hold = hold;
      if (hold != 2'h0 && instr_tick) begin
         next_hold = 2'(hold - 2'h1);
      end
      overflow = 1'b0;
      next_count = count_register;
      if (count_write) begin
         next_count = bus.wdata; // [RULE18]
         next_hold = TMC_WRITE_HOLD; // [RULE4]
      end else if (inc && hold == 2'h0) begin
         next_count = 8'(count_register + 8'h01); // [RULE1]
         overflow = (count_register == TMC_COUNT_MAX);
      end
      next_option = (bus.wr && bus.addr == TMC_ADDR_OPTION) ? bus.wdata : option;
      next_irq_ctrl = (bus.wr && bus.addr == TMC_ADDR_IRQ_CTRL) ? bus.wdata : irq_ctrl;
      // Set wins over a same-cycle software clear; enables are ignored. [RULE12] [RULE17] [RULE14]
      if (overflow) begin
         next_irq_ctrl[TMC_IRQ_FLAG] = 1'b1;
      end
      // Prescaler state has no address, so it can never be read. [RULE10]
      next_rdata = 8'h00;
      if (bus.rd) begin
         if (bus.addr == TMC_ADDR_COUNT) begin
            next_rdata = count_register;
         end else if (bus.addr == TMC_ADDR_OPTION) begin
            next_rdata = option;
         end else if (bus.addr == TMC_ADDR_IRQ_CTRL) begin
            next_rdata = irq_ctrl;
         end else begin
            next_rdata = 8'h00;
         end
      end
   end

   // Masked by enable, flag stays. [RULE13] [RULE19]
   assign IRQ = irq_ctrl[TMC_IRQ_FLAG] && irq_ctrl[TMC_IRQ_ENABLE];

   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         count_register <= TMC_COUNT_RESET;
         option <= TMC_OPTION_RESET;
         irq_ctrl <= TMC_IRQ_CTRL_RESET;
         hold <= 2'h0;
         pin_q <= 1'b0;
         RDATA <= 8'h00;
      end else begin
         count_register <= next_count;
         option <= next_option;
         irq_ctrl <= next_irq_ctrl;
         hold <= next_hold;
         pin_q <= EXTERNAL_COUNT_PIN;
         RDATA <= next_rdata;
      end
   end

   // ==========================================================
   // Checks
   // ==========================================================
   chk_flag_on_wrap: assert property (@(posedge CLOCK) disable iff (!RST_N) // [RULE12]
      overflow |=> irq_ctrl[TMC_IRQ_FLAG])
      else $error("flag not set on wrap");

   chk_wrap_to_zero: assert property (@(posedge CLOCK) disable iff (!RST_N) // [RULE1]
      overflow |=> count_register == 8'h00)
      else $error("count did not wrap");

   chk_wrap_at_max: assert property (@(posedge CLOCK) disable iff (!RST_N) // [RULE1]
      overflow |-> count_register == TMC_COUNT_MAX)
      else $error("overflow below maximum");

   chk_flag_no_enable: assert property (@(posedge CLOCK) disable iff (!RST_N) // [RULE17]
      (overflow && !irq_ctrl[TMC_IRQ_ENABLE]) |=> irq_ctrl[TMC_IRQ_FLAG])
      else $error("flag needs enable");

   chk_flag_beats_clear: assert property (@(posedge CLOCK) disable iff (!RST_N) // [RULE14]
      (overflow && bus.wr && bus.addr == TMC_ADDR_IRQ_CTRL) |=> irq_ctrl[TMC_IRQ_FLAG])
      else $error("clear beat the overflow");

   chk_flag_sticky: assert property (@(posedge CLOCK) disable iff (!RST_N) // [RULE14]
      (irq_ctrl[TMC_IRQ_FLAG] && !(bus.wr && bus.addr == TMC_ADDR_IRQ_CTRL)) |=> irq_ctrl[TMC_IRQ_FLAG])
      else $error("flag cleared by hardware");

   chk_flag_cause: assert property (@(posedge CLOCK) disable iff (!RST_N) // [RULE12]
      $rose(irq_ctrl[TMC_IRQ_FLAG]) |-> ($past(overflow) || $past(bus.wr && bus.addr == TMC_ADDR_IRQ_CTRL)))
      else $error("flag rose without cause");

   chk_irq_mask: assert property (@(posedge CLOCK) disable iff (!RST_N) // [RULE19]
      (overflow && irq_ctrl[TMC_IRQ_ENABLE] && !(bus.wr && bus.addr == TMC_ADDR_IRQ_CTRL)) |=> IRQ)
      else $error("irq not raised on wrap");

   chk_irq_blocked: assert property (@(posedge CLOCK) disable iff (!RST_N) // [RULE13]
      !irq_ctrl[TMC_IRQ_ENABLE] |-> !IRQ)
      else $error("irq while disabled");

   chk_irq_needs_flag: assert property (@(posedge CLOCK) disable iff (!RST_N) // [RULE19]
      !irq_ctrl[TMC_IRQ_FLAG] |-> !IRQ)
      else $error("irq without flag");

   chk_write_loads: assert property (@(posedge CLOCK) disable iff (!RST_N) // [RULE18]
      count_write |=> count_register == $past(bus.wdata))
      else $error("write not loaded");

   chk_write_hold: assert property (@(posedge CLOCK) disable iff (!RST_N) // [RULE4]
      count_write ##1 !count_write [*2] |-> $stable(count_register))
      else $error("hold broken");

   chk_hold_loaded: assert property (@(posedge CLOCK) disable iff (!RST_N) // [RULE4]
      count_write |=> hold == TMC_WRITE_HOLD)
      else $error("hold not loaded");

   chk_hold_blocks: assert property (@(posedge CLOCK) disable iff (!RST_N) // [RULE4]
      (hold != 2'h0 && !count_write) |=> $stable(count_register))
      else $error("counted during hold");

   chk_hold_steps: assert property (@(posedge CLOCK) disable iff (!RST_N) // [RULE4]
      (hold != 2'h0 && instr_tick && !count_write) |=> hold == 2'($past(hold) - 2'h1))
      else $error("hold did not step");

   chk_hold_waits: assert property (@(posedge CLOCK) disable iff (!RST_N) // [RULE4]
      (hold != 2'h0 && !instr_tick && !count_write) |=> $stable(hold))
      else $error("hold stepped off tick");

   chk_timer_step: assert property (@(posedge CLOCK) disable iff (!RST_N) // [RULE3]
      (!SLEEP && !clock_source_select && prescaler_assign && instr_tick && hold == 2'h0 && !count_write)
      |=> count_register == 8'($past(count_register) + 8'h01)) else $error("timer step");

   chk_timer_idle: assert property (@(posedge CLOCK) disable iff (!RST_N) // [RULE2]
      (!clock_source_select && prescaler_assign && !instr_tick && !count_write) |=> $stable(count_register))
      else $error("timer counted off tick");

   chk_pin_step: assert property (@(posedge CLOCK) disable iff (!RST_N) // [RULE5]
      (!SLEEP && clock_source_select && prescaler_assign && pin_edge && hold == 2'h0 && !count_write)
      |=> count_register == 8'($past(count_register) + 8'h01)) else $error("pin edge missed");

   chk_edge_count: assert property (@(posedge CLOCK) disable iff (!RST_N) // [RULE6]
      (clock_source_select && prescaler_assign && !pin_edge && !count_write) |=> $stable(count_register))
      else $error("count without edge");

   chk_rise_only: assert property (@(posedge CLOCK) disable iff (!RST_N) // [RULE7]
      (clock_source_select && !source_edge_select && prescaler_assign && !(!pin_q && EXTERNAL_COUNT_PIN)
      && !count_write) |=> $stable(count_register)) else $error("counted a non-rising edge");

   chk_fall_only: assert property (@(posedge CLOCK) disable iff (!RST_N) // [RULE7]
      (clock_source_select && source_edge_select && prescaler_assign && !(pin_q && !EXTERNAL_COUNT_PIN)
      && !count_write) |=> $stable(count_register)) else $error("counted a non-falling edge");

   chk_wd_raw: assert property (@(posedge CLOCK) disable iff (!RST_N) // [RULE8]
      !prescaler_assign |-> WATCHDOG_TIMEOUT_TICK == WATCHDOG_TICK)
      else $error("watchdog not raw");

   chk_wd_prescaled: assert property (@(posedge CLOCK) disable iff (!RST_N) // [RULE9]
      (prescaler_assign && !WATCHDOG_TICK) |-> !WATCHDOG_TIMEOUT_TICK)
      else $error("watchdog tick from nowhere");

   chk_wd_rate_one: assert property (@(posedge CLOCK) disable iff (!RST_N) // [RULE16]
      (prescaler_assign && prescale_rate_select == 3'h0) |-> WATCHDOG_TIMEOUT_TICK == WATCHDOG_TICK)
      else $error("watchdog ratio not one");

   chk_counter_prescaled: assert property (@(posedge CLOCK) disable iff (!RST_N) // [RULE9]
      (!prescaler_assign && !pre_out && !count_write) |=> $stable(count_register))
      else $error("counted past prescaler");

   chk_pre_isolated: assert property (@(posedge CLOCK) disable iff (!RST_N) // [RULE8]
      (prescaler_assign && !src_tick && !count_write) |=> $stable(count_register))
      else $error("counted watchdog ticks");

   chk_pre_on_tick: assert property (@(posedge CLOCK) disable iff (!RST_N) // [RULE11]
      pre_out |-> pre_in)
      else $error("prescaler tick without input");

   chk_pre_cleared: assert property (@(posedge CLOCK) disable iff (!RST_N) // [RULE9]
      (count_write && !prescaler_assign) |=> u_pre.count == 8'h00)
      else $error("prescaler not cleared");

   chk_sleep_frozen: assert property (@(posedge CLOCK) disable iff (!RST_N) // [RULE15]
      (SLEEP && !count_write) |=> $stable(count_register))
      else $error("counted in sleep");

   chk_sleep_no_wrap: assert property (@(posedge CLOCK) disable iff (!RST_N) // [RULE15]
      SLEEP |-> !overflow)
      else $error("overflow in sleep");

   chk_rdata_idle: assert property (@(posedge CLOCK) disable iff (!RST_N) // [RULE10]
      !bus.rd |=> RDATA == 8'h00)
      else $error("read data without read");

   chk_rdata_count: assert property (@(posedge CLOCK) disable iff (!RST_N) // [RULE18]
      (bus.rd && bus.addr == TMC_ADDR_COUNT) |=> RDATA == $past(count_register))
      else $error("count read wrong");

   chk_option_write: assert property (@(posedge CLOCK) disable iff (!RST_N) // [RULE9]
      (bus.wr && bus.addr == TMC_ADDR_OPTION) |=> option == $past(bus.wdata))
      else $error("option not loaded");

   chk_option_kept: assert property (@(posedge CLOCK) disable iff (!RST_N) // [RULE2]
      !(bus.wr && bus.addr == TMC_ADDR_OPTION) |=> $stable(option))
      else $error("option changed");

   chk_unmapped_read: assert property (@(posedge CLOCK) disable iff (!RST_N) // [RULE10]
      (bus.rd && bus.addr != TMC_ADDR_COUNT && bus.addr != TMC_ADDR_OPTION && bus.addr != TMC_ADDR_IRQ_CTRL)
      |=> RDATA == 8'h00) else $error("unmapped read not zero");

   // Scenario covers for the main paths.
   cov_overflow: cover property (@(posedge CLOCK) disable iff (!RST_N) overflow);
   cov_irq: cover property (@(posedge CLOCK) disable iff (!RST_N) $rose(IRQ));
   cov_counter_mode: cover property (@(posedge CLOCK) disable iff (!RST_N) clock_source_select && inc);
   cov_write_hold: cover property (@(posedge CLOCK) disable iff (!RST_N) hold == TMC_WRITE_HOLD);
   cov_wd_prescaled: cover property (@(posedge CLOCK) disable iff (!RST_N) prescaler_assign && WATCHDOG_TIMEOUT_TICK);
endmodule : tmc_timer0
`default_nettype wire

/* tb/tmc_far_model.sv */
/*
 Far-side model: drives the external count pin and the raw watchdog tick.
 Assumes it shares the block's clock and changes its outputs just after rising edges.
*/
`timescale 1ns/10ps
`default_nettype none
module tmc_far_model (
   input wire logic clk,
   output logic pin,
   output logic wd_tick
);
   initial begin
      pin = 1'b0;
      wd_tick = 1'b0;
   end
   // Each pin level is held three cycles, because the block detects edges against the previous sample.
   task automatic set_pin(input logic v);
      @(posedge clk);
      pin <= v;
      repeat (2) @(posedge clk);
   endtask : set_pin
   task automatic pulses(input int n);
      repeat (n) begin
         set_pin(1'b1);
         set_pin(1'b0);
      end
   endtask : pulses
   task automatic wd(input int n);
      repeat (n) begin
         @(posedge clk);
         wd_tick <= 1'b1;
         @(posedge clk);
         wd_tick <= 1'b0;
      end
      @(posedge clk);
   endtask : wd
endmodule : tmc_far_model
`default_nettype wire

/* tb/test_timer0_counter_prescaler.sv */
/*
 Self-checking bench for the timer/counter: register tasks on the strobe port, pin and watchdog from the far model.
 Assumes the package addresses and an instruction tick every 50 clocks.
*/
`timescale 1ns/10ps
`default_nettype none
module test_timer0_counter_prescaler;
   import tmc_pkg::*;
   logic CLOCK, RST_N, WR, RD, SLEEP, IRQ, PIN, WDT_IN, WDT_OUT;
   logic [7:0] ADDR, WDATA, RDATA, c1, c2;
   int n_mismatch = 0;
   int comparisons = 0;
   int n_wd = 0;
   tmc_timer0 u_tmc_timer0 (.CLOCK(CLOCK), .RST_N(RST_N), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
      .RDATA(RDATA), .SLEEP(SLEEP), .EXTERNAL_COUNT_PIN(PIN), .WATCHDOG_TICK(WDT_IN),
      .WATCHDOG_TIMEOUT_TICK(WDT_OUT), .IRQ(IRQ));
   tmc_far_model u_tmc_far_model (.clk(CLOCK), .pin(PIN), .wd_tick(WDT_IN));
   initial begin
      CLOCK = 1'b0;
      forever #10 CLOCK = ~CLOCK;
   end
   always @(posedge CLOCK) if (WDT_OUT === 1'b1) n_wd++;
   task automatic end_sim;
      $display("checks %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : end_sim
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      comparisons++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge CLOCK);
      WR <= 1'b1;
      ADDR <= a;
      WDATA <= d;
      @(posedge CLOCK);
      WR <= 1'b0;
   endtask : wr
   // Read data stands only in the cycle after the strobe, so it is taken just after that edge.
   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      @(posedge CLOCK);
      RD <= 1'b1;
      ADDR <= a;
      @(posedge CLOCK);
      RD <= 1'b0;
      #1 v = RDATA;
   endtask : rd
   task automatic rdc(input string what, input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] v;
      rd(a, v);
      chk(what, exp, v);
   endtask : rdc
   task automatic reload(input logic [7:0] v);
      wr(TMC_ADDR_COUNT, v);
      repeat (120) @(posedge CLOCK);
   endtask : reload
   initial begin
      RST_N = 1'b0;
      WR = 1'b0;
      RD = 1'b0;
      SLEEP = 1'b0;
      ADDR = 8'h00;
      WDATA = 8'h00;
      repeat (5) @(posedge CLOCK);
      RST_N <= 1'b1;
      // ========================================
      // Reset values and unmapped place
      rdc("count", TMC_ADDR_COUNT, TMC_COUNT_RESET);
      rdc("option", TMC_ADDR_OPTION, TMC_OPTION_RESET);
      rdc("irqctl", TMC_ADDR_IRQ_CTRL, TMC_IRQ_CTRL_RESET);
      rdc("unmapped", 8'h55, 8'h00);
      // ========================================
      // Edge select in counter mode
      wr(TMC_ADDR_OPTION, 8'h38);
      reload(8'h00);
      u_tmc_far_model.set_pin(1'b1);
      rdc("fall_r", TMC_ADDR_COUNT, 8'h00);
      u_tmc_far_model.set_pin(1'b0);
      rdc("fall_f", TMC_ADDR_COUNT, 8'h01);
      wr(TMC_ADDR_OPTION, 8'h28);
      u_tmc_far_model.set_pin(1'b1);
      rdc("rise_r", TMC_ADDR_COUNT, 8'h02);
      u_tmc_far_model.set_pin(1'b0);
      rdc("rise_f", TMC_ADDR_COUNT, 8'h02);
      // ========================================
      // Sleep freezes the count
      SLEEP <= 1'b1;
      u_tmc_far_model.pulses(3);
      SLEEP <= 1'b0;
      rdc("sleep", TMC_ADDR_COUNT, 8'h02);
      // ========================================
      // Overflow, flag with enable off, request, software clear
      wr(TMC_ADDR_IRQ_CTRL, 8'h80);
      reload(8'hFF);
      u_tmc_far_model.pulses(1);
      rdc("wrap", TMC_ADDR_COUNT, 8'h00);
      rdc("flag", TMC_ADDR_IRQ_CTRL, 8'h84);
      chk("irq_off", 8'h00, {7'h00, IRQ});
      wr(TMC_ADDR_IRQ_CTRL, 8'hA4);
      @(posedge CLOCK);
      chk("irq_on", 8'h01, {7'h00, IRQ});
      rdc("held", TMC_ADDR_IRQ_CTRL, 8'hA4);
      wr(TMC_ADDR_IRQ_CTRL, 8'h20);
      @(posedge CLOCK);
      chk("irq_clr", 8'h00, {7'h00, IRQ});
      // ========================================
      // Counter prescaler: one count short of the ratio, then exactly the ratio
      for (int r = 0; r < 8; r++) begin
         wr(TMC_ADDR_OPTION, 8'h20 | 8'(r));
         reload(8'h00);
         u_tmc_far_model.pulses((2 << r) - 1);
         rdc("pre_lo", TMC_ADDR_COUNT, 8'h00);
         u_tmc_far_model.pulses(1);
         rdc("pre_hi", TMC_ADDR_COUNT, 8'h01);
      end
      // ========================================
      // Watchdog path: prescaled when assigned, raw otherwise
      wr(TMC_ADDR_OPTION, 8'h09);
      n_wd = 0;
      u_tmc_far_model.wd(8);
      chk("wd_div2", 8'h04, 8'(n_wd));
      wr(TMC_ADDR_OPTION, 8'h00);
      n_wd = 0;
      u_tmc_far_model.wd(3);
      chk("wd_raw", 8'h03, 8'(n_wd));
      // ========================================
      // Timer mode: write hold, then one per instruction tick
      wr(TMC_ADDR_OPTION, 8'h08);
      wr(TMC_ADDR_COUNT, 8'h10);
      repeat (85) @(posedge CLOCK);
      rdc("hold", TMC_ADDR_COUNT, 8'h10);
      repeat (200) @(posedge CLOCK);
      rd(TMC_ADDR_COUNT, c1);
      repeat (498) @(posedge CLOCK);
      rd(TMC_ADDR_COUNT, c2);
      chk("rate", 8'h0A, c2 - c1);
      end_sim();
   end
endmodule : test_timer0_counter_prescaler
`default_nettype wire
